// [src/wtx_cfg.svh]
// Purpose: Constants for the transmitter drive and metal guard block
// Assumes: 40 MHz system clock
// Notes:   Long times are kept in milliseconds; cycle counts derive from them
`ifndef WTX_CFG_SVH
`define WTX_CFG_SVH

// Clock and time base
`define CLK_HZ          40000000
`define MS_PER_S        1000
`define TONE_HZ         4000
`define STARTUP_CYCLES  12'h400

// Durations in milliseconds
`define DC_BUZZ_MS      19'h001f4
`define AC_BUZZ_MS      19'h000c8
`define WARN_MS         19'h04e20
`define HALT_MS         19'h493e0
`define OT_SUSPEND_MS   19'h493e0

// Loss threshold: base 1400 mW, 100 mW per bin, all in microwatts
`define LOSS_BASE_UW    32'h00155cc0
`define LOSS_STEP_UW    32'h000186a0
`define MW_TO_UW        32'h000003e8
`define BIN_OFF         4'hf

// Register byte offsets
`define REG_CTRL        32'h00000000
`define REG_HALF_PERIOD 32'h00000004
`define REG_DEAD_TIME   32'h00000008
`define REG_RX_POWER    32'h0000000c
`define REG_STATUS      32'h00000010
`define REG_MEASURE     32'h00000014
`define REG_LOSS        32'h00000018

// Control fields and reset values
`define CTRL_XFER_BIT   0
`define CTRL_DAMP_BIT   1
`define HALF_PERIOD_RST 16'h00c8
`define DEAD_TIME_RST   8'h08

`endif

// [src/wtx_pkg.sv]
// Purpose: Types shared by the transmitter drive and metal guard block
// Assumes: Constants come from wtx_cfg.svh
// Notes:   State codes are fixed binary values
package wtx_pkg;

  typedef enum logic [1:0] {
    GUARD_NORMAL = 2'b00,
    GUARD_WARN   = 2'b01,
    GUARD_HALT   = 2'b10
  } guard_state_e;

  typedef enum logic [0:0] {
    THERM_RUN     = 1'b0,
    THERM_SUSPEND = 1'b1
  } therm_state_e;

endpackage

// [src/tick_divider.sv]
// Purpose: One-cycle enable pulse every PERIOD clocks while enabled
// Assumes: PERIOD of at least 1
// Notes:   Counter restarts whenever the enable falls
`timescale 1ns/1ps
module tick_divider #(
  parameter int PERIOD = 40000
) (
  // Clock and reset
  input  wire logic hclk,
  input  wire logic hresetn,
  // Control and pulse
  input  wire logic en,
  output logic      tick
);

  logic [31:0] cnt;
  logic [31:0] next_cnt;
  logic        next_tick;

  // Wrap at PERIOD-1 and pulse on the wrap
  always_comb begin
    next_cnt  = 32'h0;
    next_tick = 1'b0;
    if (en) begin
      if (cnt >= 32'(PERIOD - 1)) begin
        next_tick = 1'b1;
      end else begin
        next_cnt = cnt + 32'h1;
      end
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      cnt  <= 32'h0;
      tick <= 1'b0;
    end else begin
      cnt  <= next_cnt;
      tick <= next_tick;
    end
  end

endmodule

// [src/coil_wave_gen.sv]
// Purpose: 50% duty coil square wave and a narrower companion pulse
// Assumes: half_period in clocks, dead time well below half_period
// Notes:   A new half period takes effect at once, in the half cycle in progress
`timescale 1ns/1ps
module coil_wave_gen (
  // Clock and reset
  input  wire logic        hclk,
  input  wire logic        hresetn,
  // Control
  input  wire logic        run,
  input  wire logic [15:0] half_period,
  input  wire logic [7:0]  dead_time,
  // Waveforms
  output logic             main_wave,
  output logic             alt_wave
);

  logic [15:0] cnt;
  logic [15:0] next_cnt;
  logic        phase;
  logic        next_phase;
  logic        next_alt;

  // Equal high and low halves give the 50% duty
  always_comb begin
    next_cnt   = 16'h0;
    next_phase = 1'b0;
    next_alt   = 1'b0;
    if (run) begin
      if ((cnt + 16'h1) >= half_period) begin
        next_phase = ~phase;
      end else begin
        next_cnt   = cnt + 16'h1;
        next_phase = phase;
      end
      // Companion high only inside low half, trimmed at both ends
      next_alt = ~next_phase && (next_cnt >= {8'h0, dead_time})
                 && ((next_cnt + {8'h0, dead_time}) < half_period);
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      cnt       <= 16'h0;
      phase     <= 1'b0;
      main_wave <= 1'b0;
      alt_wave  <= 1'b0;
    end else begin
      cnt       <= next_cnt;
      phase     <= next_phase;
      main_wave <= next_phase;
      alt_wave  <= next_alt;
    end
  end

endmodule

// [src/wireless_tx_drive.sv]
// Purpose: Coil drive, buzzers, damping, start-up and metal guard of a
//          wireless power transmitter, with an AHB-Lite register slave
// Assumes: All inputs synchronous to hclk; measurements from an ADC
// Notes:   Long times run on a 1 ms enable tick
// Overview of operation
// RULE_01 - Transfer start drives DC buzzer high for 0.5 s once.
// RULE_02 - Transfer start gives AC buzzer a 4000 Hz burst for 0.2 s.
// RULE_03 - Coil drive is a 50% square wave at commanded frequency.
// RULE_04 - Mode select low: driver enable held high, wave on coil output only.
// RULE_05 - Mode select high: both outputs carry waves, width difference is dead-time. The code trims dead_time at both ends, a difference of 2 x dead_time.
// RULE_06 - Damping output switches a load across the half-bridge on request.
// RULE_07 - After reset a start-up sequence runs before normal operation.
// RULE_08 - Low external reset holds the device in reset.
// RULE_09 - Loss is input power minus receiver reported rectified power.
// RULE_10 - Input voltage and current are measured to derive input power.
// RULE_11 - Loss over threshold lights red and opens a 20 s warning.
// RULE_12 - Loss through the whole warning stops transfer and halts.
// RULE_13 - After five minutes halted, resume and repeat if loss persists.
// RULE_14 - Loss back under threshold during warning cancels it at once.
// RULE_15 - Threshold is 1400 mW plus bin times 100 mW.
// RULE_16 - Highest bin disables the metal guard.
// RULE_17 - Threshold pin level becomes a bin at start-up, then held.
// RULE_18 - Buzzers fire once per transfer start, no retrigger.
// RULE_19 - Over-temperature suspend retries after five minutes or receiver removal.
//
// Added by the designer: the AHB-Lite interface to the registers and the address map.
`timescale 1ns/1ps
`include "wtx_cfg.svh"
module wireless_tx_drive #(
  parameter int TICK_CYCLES    = `CLK_HZ / `MS_PER_S,
  parameter int TONE_HALF_CYCL = `CLK_HZ / (2 * `TONE_HZ)
) (
  // Clock and reset
  input  wire logic        hclk,
  input  wire logic        hresetn,
  // AHB-Lite slave
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output logic             hreadyout,
  output logic             hresp,
  output logic [31:0]      hrdata,
  // Pins and measurements
  input  wire logic        drive_mode_select,
  input  wire logic [3:0]  loss_threshold_pin,
  input  wire logic [15:0] vin_mv,
  input  wire logic [15:0] iin_ma,
  input  wire logic        over_temp,
  input  wire logic        receiver_present,
  // Outputs to power train and indicators
  output logic             coil_drive,
  output logic             gate_driver_enable,
  output logic             coil_damping_out,
  output logic             dc_buzzer,
  output logic             ac_buzzer,
  output logic             red_indicator
);

  logic        ms_tick;
  logic        tone_tick;
  logic        main_wave;
  logic        alt_wave;
  // Registers
  logic        xfer_req, damp_req;
  logic [15:0] half_period, rx_power;
  logic [7:0]  dead_time;
  logic        next_xfer_req, next_damp_req;
  logic [15:0] next_half_period, next_rx_power;
  logic [7:0]  next_dead_time;
  // Bus data phase
  logic        wr_pend, next_wr_pend;
  logic [31:0] wr_addr, next_wr_addr;
  logic [31:0] next_hrdata;
  // Start-up and bin
  logic [11:0] boot_cnt, next_boot_cnt;
  logic        started, next_started;
  logic [3:0]  bin, next_bin;
  // Measurement and loss
  logic [15:0] vin_q, iin_q, next_vin_q, next_iin_q;
  logic [31:0] loss_uw, next_loss_uw, thr_uw;
  logic        loss_over;
  // Guard and thermal
  wtx_pkg::guard_state_e guard_st, next_guard_st;
  wtx_pkg::therm_state_e therm_st, next_therm_st;
  logic [18:0] guard_ms, next_guard_ms, therm_ms, next_therm_ms;
  // Transfer and buzzers
  logic        xfer_on, xfer_on_q;
  logic [18:0] dc_ms, next_dc_ms, ac_ms, next_ac_ms;
  logic        tone, next_tone;
  logic        next_coil, next_enable, next_damp, next_dc, next_ac, next_red;

  // Zero wait state, always OKAY
  assign hreadyout = 1'b1;
  assign hresp     = 1'b0;

  tick_divider #(.PERIOD(TICK_CYCLES)) u_ms_tick (
    .hclk    (hclk),
    .hresetn (hresetn),
    .en      (1'b1),
    .tick    (ms_tick)
  );

  // Tone divider only runs during the burst so every burst starts alike
  tick_divider #(.PERIOD(TONE_HALF_CYCL)) u_tone_tick (
    .hclk    (hclk),
    .hresetn (hresetn),
    .en      (ac_ms != 19'h0),
    .tick    (tone_tick)
  );

  coil_wave_gen u_wave (
    .hclk        (hclk),
    .hresetn     (hresetn),
    .run         (xfer_on),
    .half_period (half_period),
    .dead_time   (dead_time),
    .main_wave   (main_wave),
    .alt_wave    (alt_wave)
  );

  // Register writes land in the data phase; reads answer from address phase
  always_comb begin
    next_wr_pend     = hsel && hready && htrans[1] && hwrite;
    next_wr_addr     = hready ? haddr : wr_addr;
    next_xfer_req    = xfer_req;
    next_damp_req    = damp_req;
    next_half_period = half_period;
    next_dead_time   = dead_time;
    next_rx_power    = rx_power;
    next_hrdata      = 32'h0;
    if (wr_pend) begin
      if (wr_addr == `REG_CTRL) begin
        next_xfer_req = hwdata[`CTRL_XFER_BIT];
        next_damp_req = hwdata[`CTRL_DAMP_BIT];
      end else if (wr_addr == `REG_HALF_PERIOD) begin
        next_half_period = hwdata[15:0]; // RULE_03
      end else if (wr_addr == `REG_DEAD_TIME) begin
        next_dead_time = hwdata[7:0];
      end else if (wr_addr == `REG_RX_POWER) begin
        next_rx_power = hwdata[15:0]; // RULE_09
      end
    end
    if (hsel && hready && htrans[1] && !hwrite) begin
      if (haddr == `REG_CTRL) begin
        next_hrdata = {30'h0, damp_req, xfer_req};
      end else if (haddr == `REG_HALF_PERIOD) begin
        next_hrdata = {16'h0, half_period};
      end else if (haddr == `REG_DEAD_TIME) begin
        next_hrdata = {24'h0, dead_time};
      end else if (haddr == `REG_RX_POWER) begin
        next_hrdata = {16'h0, rx_power};
      end else if (haddr == `REG_STATUS) begin
        next_hrdata = {22'h0, bin, red_indicator, therm_st, guard_st, xfer_on, started};
      end else if (haddr == `REG_MEASURE) begin
        next_hrdata = {iin_q, vin_q};
      end else if (haddr == `REG_LOSS) begin
        next_hrdata = loss_uw;
      end
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin // RULE_08
      wr_pend     <= 1'b0;
      wr_addr     <= 32'h0;
      hrdata      <= 32'h0;
      xfer_req    <= 1'b0;
      damp_req    <= 1'b0;
      half_period <= `HALF_PERIOD_RST;
      dead_time   <= `DEAD_TIME_RST;
      rx_power    <= 16'h0;
    end else begin
      wr_pend     <= next_wr_pend;
      wr_addr     <= next_wr_addr;
      hrdata      <= next_hrdata;
      xfer_req    <= next_xfer_req;
      damp_req    <= next_damp_req;
      half_period <= next_half_period;
      dead_time   <= next_dead_time;
      rx_power    <= next_rx_power;
    end
  end

  // Start-up sequence, then the threshold bin is caught once
  always_comb begin
    next_boot_cnt = boot_cnt;
    next_started  = started;
    next_bin      = bin;
    if (!started) begin
      if (boot_cnt >= `STARTUP_CYCLES - 12'h1) begin
        next_started = 1'b1; // RULE_07
        next_bin     = loss_threshold_pin; // RULE_17
      end else begin
        next_boot_cnt = boot_cnt + 12'h1;
      end
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      boot_cnt <= 12'h0;
      started  <= 1'b0;
      bin      <= `BIN_OFF;
    end else begin
      boot_cnt <= next_boot_cnt;
      started  <= next_started;
      bin      <= next_bin;
    end
  end

  // Input power in microwatts less the reported rectified power
  always_comb begin
    next_vin_q   = vin_mv; // RULE_10
    next_iin_q   = iin_ma; // RULE_10
    next_loss_uw = 32'h0;
    if ((vin_q * iin_q) > ({16'h0, rx_power} * `MW_TO_UW)) begin
      next_loss_uw = (vin_q * iin_q) - ({16'h0, rx_power} * `MW_TO_UW); // RULE_09
    end
  end

  assign thr_uw    = `LOSS_BASE_UW + ({28'h0, bin} * `LOSS_STEP_UW); // RULE_15
  // Only judged while power flows; the top bin switches the guard off
  assign loss_over = xfer_on && (bin != `BIN_OFF) && (loss_uw > thr_uw); // RULE_16

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      vin_q   <= 16'h0;
      iin_q   <= 16'h0;
      loss_uw <= 32'h0;
    end else begin
      vin_q   <= next_vin_q;
      iin_q   <= next_iin_q;
      loss_uw <= next_loss_uw;
    end
  end

  // Metal guard: warn, halt, timed retry
  always_comb begin
    next_guard_st = guard_st;
    next_guard_ms = guard_ms;
    case (guard_st)
      wtx_pkg::GUARD_NORMAL: begin
        if (loss_over) begin
          next_guard_st = wtx_pkg::GUARD_WARN; // RULE_11
          next_guard_ms = `WARN_MS;
        end
      end
      wtx_pkg::GUARD_WARN: begin
        if (!loss_over) begin
          next_guard_st = wtx_pkg::GUARD_NORMAL; // RULE_14
        end else if (guard_ms == 19'h0) begin
          next_guard_st = wtx_pkg::GUARD_HALT; // RULE_12
          next_guard_ms = `HALT_MS;
        end else if (ms_tick) begin
          next_guard_ms = guard_ms - 19'h1;
        end
      end
      wtx_pkg::GUARD_HALT: begin
        if (guard_ms == 19'h0) begin
          next_guard_st = wtx_pkg::GUARD_NORMAL; // RULE_13
        end else if (ms_tick) begin
          next_guard_ms = guard_ms - 19'h1;
        end
      end
      default: begin
        next_guard_st = wtx_pkg::GUARD_NORMAL;
      end
    endcase
  end

  // Thermal suspend: retry after timeout or when the receiver leaves
  always_comb begin
    next_therm_st = therm_st;
    next_therm_ms = therm_ms;
    case (therm_st)
      wtx_pkg::THERM_RUN: begin
        if (over_temp) begin
          next_therm_st = wtx_pkg::THERM_SUSPEND;
          next_therm_ms = `OT_SUSPEND_MS;
        end
      end
      wtx_pkg::THERM_SUSPEND: begin
        if (!receiver_present || therm_ms == 19'h0) begin
          next_therm_st = wtx_pkg::THERM_RUN; // RULE_19
        end else if (ms_tick) begin
          next_therm_ms = therm_ms - 19'h1;
        end
      end
      default: begin
        next_therm_st = wtx_pkg::THERM_RUN;
      end
    endcase
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      guard_st <= wtx_pkg::GUARD_NORMAL;
      guard_ms <= 19'h0;
      therm_st <= wtx_pkg::THERM_RUN;
      therm_ms <= 19'h0;
    end else begin
      guard_st <= next_guard_st;
      guard_ms <= next_guard_ms;
      therm_st <= next_therm_st;
      therm_ms <= next_therm_ms;
    end
  end

  // Transfer runs only once started, requested and not stopped
  assign xfer_on = started && xfer_req && (guard_st != wtx_pkg::GUARD_HALT)
                   && (therm_st == wtx_pkg::THERM_RUN);

  // Buzzer timers load only on the rising edge of transfer
  always_comb begin
    next_dc_ms = dc_ms;
    next_ac_ms = ac_ms;
    next_tone  = tone;
    if (xfer_on && !xfer_on_q) begin
      next_dc_ms = `DC_BUZZ_MS; // RULE_18
      next_ac_ms = `AC_BUZZ_MS; // RULE_18
      next_tone  = 1'b0;
    end else begin
      if (ms_tick && dc_ms != 19'h0) begin
        next_dc_ms = dc_ms - 19'h1; // RULE_01
      end
      if (ms_tick && ac_ms != 19'h0) begin
        next_ac_ms = ac_ms - 19'h1; // RULE_02
      end
      if (tone_tick) begin
        next_tone = ~tone; // RULE_02
      end
    end
  end

  // Pin outputs, all from flip-flops
  always_comb begin
    next_coil   = xfer_on && main_wave; // RULE_03
    next_enable = started; // RULE_04
    if (drive_mode_select) begin
      next_enable = xfer_on && alt_wave; // RULE_05
    end
    next_damp = started && damp_req; // RULE_06
    next_dc   = next_dc_ms != 19'h0; // RULE_01
    next_ac   = (next_ac_ms != 19'h0) && next_tone; // RULE_02
    next_red  = next_guard_st != wtx_pkg::GUARD_NORMAL; // RULE_11
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      xfer_on_q          <= 1'b0;
      dc_ms              <= 19'h0;
      ac_ms              <= 19'h0;
      tone               <= 1'b0;
      coil_drive         <= 1'b0;
      gate_driver_enable <= 1'b0;
      coil_damping_out   <= 1'b0;
      dc_buzzer          <= 1'b0;
      ac_buzzer          <= 1'b0;
      red_indicator      <= 1'b0;
    end else begin
      xfer_on_q          <= xfer_on;
      dc_ms              <= next_dc_ms;
      ac_ms              <= next_ac_ms;
      tone               <= next_tone;
      coil_drive         <= next_coil;
      gate_driver_enable <= next_enable;
      coil_damping_out   <= next_damp;
      dc_buzzer          <= next_dc;
      ac_buzzer          <= next_ac;
      red_indicator      <= next_red;
    end
  end

endmodule

// [verification/wtx_monitor.sv]
// Purpose: Port-level checks on the transmitter drive block
// Assumes: Bound to wireless_tx_drive, one clock domain
// Notes:   Buzzer length scales with TICK_CYCLES
`timescale 1ns/1ps
module wtx_monitor #(
  parameter int TICK_CYCLES    = 40000,
  parameter int TONE_HALF_CYCL = 5000
) (
  // Clock and reset
  input wire logic hclk,
  input wire logic hresetn,
  // Bus response
  input wire logic hreadyout,
  input wire logic hresp,
  // Pins
  input wire logic drive_mode_select,
  input wire logic over_temp,
  input wire logic coil_drive,
  input wire logic gate_driver_enable,
  input wire logic dc_buzzer,
  input wire logic ac_buzzer,
  input wire logic red_indicator
);
  default clocking @(posedge hclk); endclocking
  default disable iff (!hresetn);

  logic [31:0] dc_len;
  logic [31:0] next_dc_len;

  // High time of the DC buzzer, still whole at its falling edge
  always_comb next_dc_len = dc_buzzer ? dc_len + 32'h1 : 32'h0;
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) dc_len <= 32'h0;
    else dc_len <= next_dc_len;
  end

  property p_okay;
    hreadyout && !hresp;
  endproperty
  a_okay: assert property (p_okay) else $error("bus response not ready and okay");

  property p_startup;
    $rose(hresetn) |-> (!coil_drive && !gate_driver_enable && !dc_buzzer) [*8];
  endproperty
  a_startup: assert property (p_startup) else $error("drive on in start-up");

  property p_mode0;
    (gate_driver_enable && !drive_mode_select) [*2] |=> gate_driver_enable;
  endproperty
  a_mode0: assert property (p_mode0) else $error("driver enable dropped in mode 0");

  property p_mode1;
    drive_mode_select [*3] |-> !(coil_drive && gate_driver_enable);
  endproperty
  a_mode1: assert property (p_mode1) else $error("waves overlap in dual mode");

  property p_dc_len;
    $fell(dc_buzzer) |-> dc_len >= 500 * TICK_CYCLES - 2 && dc_len <= 500 * TICK_CYCLES + 2;
  endproperty
  a_dc_len: assert property (p_dc_len) else $error("dc buzzer pulse length wrong");

  property p_ac_start;
    $rose(dc_buzzer) |-> ##[0:4] ac_buzzer;
  endproperty
  a_ac_start: assert property (p_ac_start) else $error("ac buzzer silent at start");

  property p_warn_runs;
    $rose(red_indicator) |-> ##[1:300] $changed(coil_drive);
  endproperty
  a_warn_runs: assert property (p_warn_runs) else $error("coil stopped in warning");

  property p_therm;
    $rose(over_temp) |-> ##6 (!coil_drive) [*8];
  endproperty
  a_therm: assert property (p_therm) else $error("coil runs in thermal suspend");
endmodule

bind wireless_tx_drive wtx_monitor #(
  .TICK_CYCLES(TICK_CYCLES), .TONE_HALF_CYCL(TONE_HALF_CYCL)
) u_wtx_monitor (
  .hclk(hclk), .hresetn(hresetn), .hreadyout(hreadyout), .hresp(hresp),
  .drive_mode_select(drive_mode_select), .over_temp(over_temp),
  .coil_drive(coil_drive), .gate_driver_enable(gate_driver_enable),
  .dc_buzzer(dc_buzzer), .ac_buzzer(ac_buzzer), .red_indicator(red_indicator)
);

// [verification/power_train_model.sv]
// Purpose: Behavioural coil power train feeding input measurements
// Assumes: Fixed 5 V supply, load current set by the bench
// Notes:   Current falls to zero once the coil stops switching
`timescale 1ns/1ps
module power_train_model (
  // Clock
  input  wire logic        hclk,
  // Drive from the block
  input  wire logic        coil_drive,
  // Load chosen by the bench
  input  wire logic [15:0] load_ma,
  // Measurements back to the block
  output logic      [15:0] vin_mv,
  output logic      [15:0] iin_ma
);
  logic [7:0] idle = 8'hff;
  logic       last = 1'b0;

  // Cycles since the last coil edge, saturating
  always @(posedge hclk) begin
    last <= coil_drive;
    idle <= (coil_drive != last) ? 8'h00 : (idle == 8'hff ? idle : idle + 8'h01);
  end

  // A stopped coil draws nothing, so a halt shows as zero current
  assign vin_mv = 16'h1388;
  assign iin_ma = (idle < 8'hf0) ? load_ma : 16'h0000;
endmodule

// [verification/tb_top.sv]
// Purpose: Self-checking bench for the transmitter drive block
// Assumes: 1 ms tick shrunk to one cycle, tone half period 2 cycles
// Notes:   The five-minute halt retry is too long to run here
`timescale 1ns/1ps
`include "wtx_cfg.svh"
module tb_top;
  logic        hclk = 1'b0;
  logic        hresetn = 1'b0;
  logic        hsel = 1'b0;
  logic        hwrite = 1'b0;
  logic [1:0]  htrans = 2'h0;
  logic [2:0]  hsize = 3'h2;
  logic [31:0] haddr = 32'h0;
  logic [31:0] hwdata = 32'h0;
  logic        drive_mode_select = 1'b0;
  logic [3:0]  loss_threshold_pin = 4'h1;
  logic        over_temp = 1'b0;
  logic        receiver_present = 1'b1;
  logic [15:0] load_ma = 16'h0;
  logic        hreadyout, hresp, coil_drive, gate_driver_enable;
  logic        coil_damping_out, dc_buzzer, ac_buzzer, red_indicator;
  logic [31:0] hrdata, rdata;
  logic [15:0] vin_mv, iin_ma;
  int          fail_count = 0;
  int          samples_checked = 0;
  int          ch, cr, gh, ov, dh, ar;

  always #12.5 hclk = ~hclk;

  wireless_tx_drive #(.TICK_CYCLES(1), .TONE_HALF_CYCL(2)) u_wireless_tx_drive (
    .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
    .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata),
    .drive_mode_select(drive_mode_select), .loss_threshold_pin(loss_threshold_pin),
    .vin_mv(vin_mv), .iin_ma(iin_ma), .over_temp(over_temp),
    .receiver_present(receiver_present), .coil_drive(coil_drive),
    .gate_driver_enable(gate_driver_enable), .coil_damping_out(coil_damping_out),
    .dc_buzzer(dc_buzzer), .ac_buzzer(ac_buzzer), .red_indicator(red_indicator));

  power_train_model u_power_train_model (
    .hclk(hclk), .coil_drive(coil_drive), .load_ma(load_ma),
    .vin_mv(vin_mv), .iin_ma(iin_ma));

  task automatic give_verdict;
    $display("checks %0d mismatches %0d", samples_checked, fail_count);
    if (fail_count == 0 && samples_checked > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    samples_checked++;
    if (got !== exp) begin
      fail_count++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic cyc(input int n);
    repeat (n) @(posedge hclk);
  endtask

  // Single word transfer; read data taken at the data phase edge
  task automatic bus(input logic wr, input logic [31:0] a, input logic [31:0] d);
    @(posedge hclk);
    hsel <= 1'b1;
    haddr <= a;
    hwrite <= wr;
    htrans <= 2'h2;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    rdata = hrdata;
  endtask

  task automatic rd(input logic [31:0] a, input logic [31:0] m, input logic [31:0] exp);
    bus(1'b0, a, 32'h0);
    chk(rdata & m, exp);
  endtask

  // Edge and level counts over n cycles
  task automatic meas(input int n);
    logic pc, pa;
    {ch, cr, gh, ov, dh, ar} = '0;
    pc = coil_drive;
    pa = ac_buzzer;
    repeat (n) begin
      @(posedge hclk);
      ch += coil_drive;
      cr += coil_drive & !pc;
      gh += gate_driver_enable;
      ov += coil_drive & gate_driver_enable;
      dh += dc_buzzer;
      ar += ac_buzzer & !pa;
      pc = coil_drive;
      pa = ac_buzzer;
    end
  endtask

  task automatic t_regs;
    chk(gate_driver_enable, 1'b0);
    rd(`REG_HALF_PERIOD, 32'hffffffff, 32'h000000c8);
    rd(`REG_DEAD_TIME, 32'hffffffff, 32'h00000008);
    rd(`REG_CTRL, 32'hffffffff, 32'h0);
    bus(1'b1, 32'h00000040, 32'hffffffff);
    rd(32'h00000040, 32'hffffffff, 32'h0);
    rd(`REG_STATUS, 32'h1, 32'h0);
    cyc(1100);
    rd(`REG_STATUS, 32'h3c1, 32'h041);
    chk(gate_driver_enable, 1'b1);
  endtask

  task automatic t_buzz;
    loss_threshold_pin <= 4'h3;
    bus(1'b1, `REG_HALF_PERIOD, 32'h0000000a);
    bus(1'b1, `REG_CTRL, 32'h1);
    meas(700);
    chk(dh inside {[498:502]}, 1'b1);
    chk(ar inside {[49:51]}, 1'b1);
    meas(200);
    chk(ch, 100);
    chk(cr, 10);
    chk(gh, 200);
    chk(dh + ar, 0);
    bus(1'b1, `REG_CTRL, 32'h0);
    bus(1'b1, `REG_CTRL, 32'h1);
    meas(20);
    chk(dh > 0, 1'b1);
  endtask

  task automatic t_dual;
    bus(1'b1, `REG_HALF_PERIOD, 32'h00000014);
    bus(1'b1, `REG_DEAD_TIME, 32'h00000004);
    drive_mode_select <= 1'b1;
    meas(60);
    meas(400);
    chk(ch, 200);
    chk(gh, 120);
    chk(ov, 0);
    drive_mode_select <= 1'b0;
    bus(1'b1, `REG_HALF_PERIOD, 32'h0000000a);
  endtask

  task automatic t_damp;
    bus(1'b1, `REG_CTRL, 32'h3);
    cyc(2);
    chk(coil_damping_out, 1'b1);
    bus(1'b1, `REG_CTRL, 32'h1);
    cyc(2);
    chk(coil_damping_out, 1'b0);
  endtask

  task automatic t_therm;
    over_temp <= 1'b1;
    cyc(10);
    rd(`REG_STATUS, 32'h12, 32'h10);
    over_temp <= 1'b0;
    cyc(10);
    rd(`REG_STATUS, 32'h12, 32'h10);
    receiver_present <= 1'b0;
    cyc(4);
    receiver_present <= 1'b1;
    cyc(4);
    rd(`REG_STATUS, 32'h12, 32'h02);
  endtask

  // Bin 1 gives 1500 mW; a later pin change must not move it
  task automatic t_loss;
    bus(1'b1, `REG_RX_POWER, 32'h000003e8);
    load_ma <= 16'h0190;
    cyc(10);
    rd(`REG_MEASURE, 32'hffffffff, 32'h01901388);
    rd(`REG_LOSS, 32'hffffffff, 32'h000f4240);
    load_ma <= 16'h01f4;
    cyc(10);
    chk(red_indicator, 1'b0);
    load_ma <= 16'h01f6;
    cyc(6);
    chk(red_indicator, 1'b1);
    load_ma <= 16'h0190;
    cyc(6);
    chk(red_indicator, 1'b0);
    rd(`REG_STATUS, 32'h3ce, 32'h042);
    load_ma <= 16'h01f6;
    cyc(19950);
    meas(30);
    chk(cr > 0, 1'b1);
    cyc(60);
    rd(`REG_STATUS, 32'h2e, 32'h28);
  endtask

  task automatic t_off;
    loss_threshold_pin <= 4'hf;
    hresetn <= 1'b0;
    cyc(4);
    chk({coil_drive, red_indicator, dc_buzzer}, 3'h0);
    hresetn <= 1'b1;
    bus(1'b1, `REG_CTRL, 32'h1);
    bus(1'b1, `REG_HALF_PERIOD, 32'h0000000a);
    meas(40);
    chk(cr, 0);
    cyc(1100);
    load_ma <= 16'h03e8;
    cyc(100);
    chk(red_indicator, 1'b0);
    meas(40);
    chk(cr, 2);
  endtask

  initial begin
    cyc(4);
    hresetn <= 1'b1;
    t_regs;
    t_buzz;
    t_dual;
    t_damp;
    t_therm;
    t_loss;
    t_off;
    give_verdict;
  end

  // Watchdog well above the expected 24k cycles
  initial begin
    cyc(60000);
    fail_count++;
    give_verdict;
  end
endmodule
